/* File: dv/mmia_checker.sv */
/*
 * Port checker for the memory map and interrupt glue, bound to the top.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module mmia_checker
   import mmia_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire mmia_pm_req_t pm_req_in,
   input wire logic [13:0] pm_rom_addr_out,
   input wire mmia_dm_req_t dm_req_in,
   input wire logic [15:0] dm_rdata_out,
   input wire logic peri_sel_out,
   input wire logic peri_wr_out,
   input wire logic [7:0] peri_addr_out,
   input wire logic [15:0] peri_wdata_out,
   input wire logic [13:0] boot_fetch_addr_out,
   input wire mmia_core_src_t core_src_in,
   input wire logic [7:0] core_mask_in,
   input wire logic [25:0] peri_mask_in,
   input wire logic peripheral_irq_line_out,
   input wire logic [7:0] core_pend_out,
   input wire logic irq_valid_out,
   input wire logic [2:0] irq_slot_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   logic dm_peri, dm_none, pm_rom;
   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   assign dm_peri = dm_req_in.addr >= DM_PERI_BASE && dm_req_in.addr <= DM_PERI_END;
   assign dm_none = !dm_peri && !(dm_req_in.addr >= DM_RAM_BASE && dm_req_in.addr <= DM_RAM_END);
   assign pm_rom = pm_req_in.addr >= PM_ROM_BASE && pm_req_in.addr <= PM_ROM_END;
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_boot_entry: assert property (boot_fetch_addr_out == 14'h0800)
      else $error("boot fetch address wrong");
   a_peri_write: assert property (dm_req_in.wr && dm_peri |=> peri_sel_out && peri_wr_out
      && peri_addr_out == $past(dm_req_in.addr[7:0]) && peri_wdata_out == $past(dm_req_in.wdata))
      else $error("peripheral write strobe wrong");
   a_peri_read: assert property (dm_req_in.rd && dm_peri |=> peri_sel_out && !peri_wr_out
      && peri_addr_out == $past(dm_req_in.addr[7:0])) else $error("peripheral read strobe wrong");
   a_no_stray: assert property (peri_sel_out |-> $past((dm_req_in.rd || dm_req_in.wr) && dm_peri))
      else $error("peripheral strobe without access");
   a_dm_zero: assert property (dm_req_in.rd && dm_none && !$past(dm_req_in.rd && dm_peri)
      |-> ##2 dm_rdata_out == 16'h0000) else $error("unmapped read not zero");
   a_rom_addr: assert property (pm_req_in.rd && pm_rom |=> pm_rom_addr_out == $past(pm_req_in.addr))
      else $error("rom address not passed on");
   a_irq_valid: assert property (irq_valid_out == (|core_pend_out))
      else $error("valid does not match pending");
   a_irq_slot: assert property (irq_valid_out |-> core_pend_out[irq_slot_out]
      && (core_pend_out & ((8'h01 << irq_slot_out) - 8'h01)) == 8'h00) else $error("slot wrong");
   a_core_masked: assert property (core_mask_in == $past(core_mask_in)
      && core_mask_in == $past(core_mask_in, 2) |-> (core_pend_out & ~core_mask_in) == 8'h00)
      else $error("masked slot pending");
   a_peri_masked: assert property (peri_mask_in == 26'h0 && $past(peri_mask_in) == 26'h0
      |-> !peripheral_irq_line_out) else $error("masked peripheral line high");
   a_timer_slot: assert property (core_src_in.timer && core_mask_in[SLOT_TIMER]
      ##1 core_mask_in[SLOT_TIMER] |-> core_pend_out[SLOT_TIMER]) else $error("timer not pending");
   c_peri_write: cover property (dm_req_in.wr && dm_peri);
   c_rom_write: cover property (pm_req_in.wr && pm_rom);
   c_low_slot: cover property (irq_valid_out && irq_slot_out == 3'h7);
endmodule
bind mmia_top mmia_checker u_mmia_checker (.sys_clk_in, .rst_b_in, .pm_req_in, .pm_rom_addr_out,
   .dm_req_in, .dm_rdata_out, .peri_sel_out, .peri_wr_out, .peri_addr_out, .peri_wdata_out,
   .boot_fetch_addr_out, .core_src_in, .core_mask_in, .peri_mask_in, .peripheral_irq_line_out,
   .core_pend_out, .irq_valid_out, .irq_slot_out);

/* File: dv/mmia_far_model.sv */
/*
 * Far-side model: mask ROM holding a fixed image, and the peripheral register file.
 * Assumes strobes from the glue are registered and one clock wide.
 */
`timescale 1ns/1ps
module mmia_far_model (
   input wire logic sys_clk_in,
   input wire logic [13:0] rom_addr_in,
   output logic [23:0] rom_data_out,
   input wire logic sel_in,
   input wire logic wr_in,
   input wire logic [7:0] addr_in,
   input wire logic [15:0] wdata_in,
   output logic [15:0] rdata_out
);
   logic [15:0] regs [256];
   logic [7:0] addr_q;
   logic ans_q = 1'b0;
   logic tog_q = 1'b0;
   // Fixed word per address stands in for the monitor image
   assign rom_data_out = {10'h2a5, rom_addr_in};
   // Outside the answer cycle the bus toggles, so a late sample never passes
   assign rdata_out = ans_q ? regs[addr_q] : {16{tog_q}};
   initial for (int i = 0; i < 256; i++) regs[i] = 16'h1000 + i[15:0];
   always @(posedge sys_clk_in) begin
      if (sel_in && wr_in) regs[addr_in] <= wdata_in;
      ans_q <= sel_in && !wr_in;
      addr_q <= addr_in;
      tog_q <= !tog_q;
   end
endmodule

/* File: dv/test_mmia_top.sv */
/*
 * Self-checking bench for the memory map and interrupt glue.
 * Assumes the far-side model answers ROM and peripheral reads; 8 ns clock.
 */
`timescale 1ns/1ps
module test_mmia_top
   import mmia_pkg::*;
;
   logic sys_clk_in, rst_b_in, port1_as_flags_in, ext_request_a_b_in, ext_request_b_b_in;
   logic pwm_period_pulse_in, pwm_shutdown_input_in, peri_sel_out, peri_wr_out;
   logic peripheral_irq_line_out, irq_valid_out;
   mmia_pm_req_t pm_req_in;
   mmia_dm_req_t dm_req_in;
   mmia_core_src_t core_src_in;
   logic [23:0] pm_rdata_out, pm_rom_data_in, digital_io_lines_in;
   logic [13:0] pm_rom_addr_out, boot_fetch_addr_out, user_entry_addr_out;
   logic [15:0] dm_rdata_out, peri_wdata_out, peri_rdata_in;
   logic [7:0] peri_addr_out, core_mask_in, core_pend_out;
   logic [25:0] peri_mask_in;
   logic [2:0] irq_slot_out;
   logic [31:0] rs, r;
   int miscompares, n_tests, cyc;
   logic [23:0] pm_m [int], exp_pm [int];
   logic [15:0] dm_m [int], pr_m [int], exp_dm [int];
   logic [13:0] qa [$];
   mmia_top u_mmia_top (.sys_clk_in, .rst_b_in, .pm_req_in, .pm_rdata_out, .pm_rom_addr_out,
      .pm_rom_data_in, .dm_req_in, .dm_rdata_out, .peri_sel_out, .peri_wr_out, .peri_addr_out,
      .peri_wdata_out, .peri_rdata_in, .boot_fetch_addr_out, .user_entry_addr_out,
      .port1_as_flags_in, .ext_request_a_b_in, .ext_request_b_b_in, .core_src_in,
      .digital_io_lines_in, .pwm_period_pulse_in, .pwm_shutdown_input_in, .core_mask_in,
      .peri_mask_in, .peripheral_irq_line_out, .core_pend_out, .irq_valid_out, .irq_slot_out);
   mmia_far_model u_mmia_far_model (.sys_clk_in, .rom_addr_in(pm_rom_addr_out),
      .rom_data_out(pm_rom_data_in), .sel_in(peri_sel_out), .wr_in(peri_wr_out),
      .addr_in(peri_addr_out), .wdata_in(peri_wdata_out), .rdata_out(peri_rdata_in));
   // ----------------------------------------
   // Helpers and reference model
   // ----------------------------------------
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk_in) begin
         pm_req_in <= '0;
         dm_req_in <= '0;
      end
   endtask
   // Read data lands three counts after the drive edge, peripheral one more
   task automatic pm_op(input logic w, input logic [13:0] a, input logic [23:0] d);
      @(posedge sys_clk_in);
      pm_req_in <= {!w, w, a, d};
      if (w && a < PM_ROM_BASE) pm_m[a] = d;
      else if (!w) exp_pm[cyc + 3] = (a < PM_ROM_BASE) ? pm_m[a] : {10'h2a5, a};
   endtask
   task automatic dm_op(input logic w, input logic [13:0] a, input logic [15:0] d);
      logic ram, prf;
      ram = a >= DM_RAM_BASE && a <= DM_RAM_END;
      prf = a >= DM_PERI_BASE && a <= DM_PERI_END;
      @(posedge sys_clk_in);
      dm_req_in <= {!w, w, a, d};
      if (w && ram) dm_m[a] = d;
      if (w && prf) pr_m[a[7:0]] = d;
      if (!w) exp_dm[cyc + (prf ? 4 : 3)] = ram ? dm_m[a] : !prf ? 16'h0000 :
         pr_m.exists(a[7:0]) ? pr_m[a[7:0]] : 16'h1000 + a[7:0];
      // A gap keeps the late peripheral answer clear of the next
      if (!w && prf) begin
         @(posedge sys_clk_in);
         dm_req_in <= '0;
      end
   endtask
   task automatic irq_chk();
      logic [25:0] pv;
      logic [7:0] sl;
      int k;
      idle(10);
      @(negedge sys_clk_in);
      pv = {pwm_shutdown_input_in, pwm_period_pulse_in, digital_io_lines_in} & peri_mask_in;
      sl = {core_src_in.timer, port1_as_flags_in ? !ext_request_a_b_in : core_src_in.port1_rx,
         port1_as_flags_in ? !ext_request_b_b_in : core_src_in.port1_tx, core_src_in.port0_rx,
         core_src_in.port0_tx, |pv, core_src_in.soft0, core_src_in.soft1} & core_mask_in;
      k = 0;
      while (k < 7 && !sl[k]) k++;
      chk(peripheral_irq_line_out, |pv);
      chk(core_pend_out, sl);
      chk(irq_valid_out, |sl);
      if (|sl) chk(irq_slot_out, k);
      @(posedge sys_clk_in);
   endtask
   task automatic end_sim();
      $display("n_tests=%0d miscompares=%0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ----------------------------------------
   // Clock, read-data watch and time limit
   // ----------------------------------------
   initial begin
      sys_clk_in = 1'b0;
      forever #4 sys_clk_in = ~sys_clk_in;
   end
   always @(posedge sys_clk_in) cyc <= cyc + 1;
   // Read data is zero in any cycle without an answer
   always @(negedge sys_clk_in) begin
      if (rst_b_in) begin
         chk(pm_rdata_out, exp_pm.exists(cyc) ? exp_pm[cyc] : 24'h0);
         chk(dm_rdata_out, exp_dm.exists(cyc) ? exp_dm[cyc] : 16'h0);
      end
   end
   initial begin
      repeat (20000) @(posedge sys_clk_in);
      miscompares++;
      end_sim();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rs = 32'h6437;
      cyc = 0;
      {pm_req_in, dm_req_in, core_src_in, digital_io_lines_in} = '0;
      {port1_as_flags_in, pwm_period_pulse_in, pwm_shutdown_input_in} = '0;
      {ext_request_a_b_in, ext_request_b_b_in} = 2'b11;
      {core_mask_in, peri_mask_in} = '0;
      rst_b_in = 1'b0;
      repeat (10) @(posedge sys_clk_in);
      chk(boot_fetch_addr_out, 14'h0800);
      chk(user_entry_addr_out, 14'h0030);
      chk(pm_rom_addr_out, 14'h0800);
      rst_b_in <= 1'b1;
      // Program RAM back to back, a dropped ROM write, then RAM reads and ROM reads
      qa = {14'h0000, 14'h07ff, 14'h0010};
      repeat (13) begin r = xs(); qa.push_back({3'h0, r[10:0]}); end
      foreach (qa[i]) begin r = xs(); pm_op(1'b1, qa[i], r[23:0]); end
      r = xs();
      pm_op(1'b1, 14'h0810, r[23:0]);
      foreach (qa[i]) pm_op(1'b0, qa[i], 24'h0);
      foreach (qa[i]) pm_op(1'b0, qa[i] | 14'h0800, 24'h0);
      idle(6);
      // Data RAM, peripheral edges and unmapped holes that share low bits but read zero
      qa = {14'h3800, 14'h3bff, 14'h3810, 14'h2000, 14'h20ff, 14'h2005, 14'h1fff, 14'h2100,
         14'h37ff, 14'h3c00, 14'h0010};
      repeat (8) begin r = xs(); qa.push_back(14'h3800 | {4'h0, r[9:0]}); end
      foreach (qa[i]) begin r = xs(); dm_op(1'b1, qa[i], r[15:0]); end
      foreach (qa[i]) dm_op(1'b0, qa[i], 16'h0);
      dm_op(1'b0, 14'h2080, 16'h0);
      idle(6);
      // Core sources and I/O lines high, PWM inputs low; masking the winner moves the grant down
      core_src_in <= '1;
      digital_io_lines_in <= '1;
      peri_mask_in <= '1;
      for (int k = 0; k < 8; k++) begin
         core_mask_in <= 8'hff << k;
         irq_chk();
      end
      // Each peripheral source alone, enabled then masked
      core_mask_in <= 8'hff;
      for (int j = 0; j < 52; j++) begin
         {pwm_shutdown_input_in, pwm_period_pulse_in, digital_io_lines_in} <= 26'h1 << (j / 2);
         peri_mask_in <= (j % 2) ? ~(26'h1 << (j / 2)) : 26'h3ffffff;
         irq_chk();
      end
      for (int i = 0; i < 40; i++) begin
         r = xs();
         core_src_in <= r[6:0];
         digital_io_lines_in <= r[30:7];
         r = xs();
         core_mask_in <= r[7:0];
         peri_mask_in <= (i % 4 == 0) ? 26'h0 : r[31:6];
         r = xs();
         {port1_as_flags_in, ext_request_a_b_in, ext_request_b_b_in} <= r[2:0];
         {pwm_period_pulse_in, pwm_shutdown_input_in} <= r[4:3];
         irq_chk();
      end
      end_sim();
   end
endmodule

/* File: hdl/mmia_pkg.sv */
/*
 * Constants and carrier types for the memory map and interrupt aggregation glue.
 * Assumes a single processor cycle clock and an active-low asynchronous master reset.
 */
//
// Overview of operation
// - Program addresses 0x0000 up to the ROM base select one 2K x 24-bit RAM block.
// - Program ROM starts at 0x0800, directly above the program RAM.
// - Data addresses from 0x3800 select a 1K x 16-bit data RAM block.
// - Peripheral registers are reached by data accesses in a region starting at 0x2000.
// - The 2K x 24-bit ROM at 0x0800 holds the monitor image, supplied through a port.
// - In monitor mode the host reaches registers and both memories through the core buses.
// - Thirty-three interrupt sources are accepted, seven core and twenty-six peripheral.
// - Core sources are port zero rx/tx, port one rx/tx or ext requests, timer, two software.
// - Peripheral sources are 24 digital I/O lines plus PWM period pulse and shutdown input.
// - All peripheral requests are combined onto the one peripheral interrupt line.
// - Sources resolve by fixed priority and each has its own mask bit.
// - After reset release the first fetch address is the monitor entry 0x0800.
// - The vector table occupies program RAM 0x0000 to 0x002F, filled by the monitor.
// - After boot load the user program entry is 0x0030.
//
package mmia_pkg;

   // ------------------------------------------------------------------
   // Address map
   // ------------------------------------------------------------------
   localparam int ADDR_W = 14;
   localparam logic [13:0] PM_RAM_BASE = 14'h0000;
   localparam logic [13:0] PM_ROM_BASE = 14'h0800;
   localparam logic [13:0] PM_ROM_END = 14'h0fff;
   localparam logic [13:0] PM_VEC_END = 14'h002f;
   localparam logic [13:0] PM_USER_ENTRY = 14'h0030;
   localparam logic [13:0] DM_PERI_BASE = 14'h2000;
   localparam logic [13:0] DM_PERI_END = 14'h20ff;
   localparam logic [13:0] DM_RAM_BASE = 14'h3800;
   localparam logic [13:0] DM_RAM_END = 14'h3bff;
   localparam int PM_DEPTH = 2048;
   localparam int DM_DEPTH = 1024;

   // ------------------------------------------------------------------
   // Interrupt sources
   // ------------------------------------------------------------------
   localparam int CORE_IRQ_N = 8;
   localparam int PERI_IRQ_N = 26;
   localparam int DIO_N = 24;
   localparam logic [7:0] CORE_MASK_RST = 8'h00;
   localparam logic [25:0] PERI_MASK_RST = 26'h0000000;

   // Core slot order, lowest index wins
   localparam int SLOT_SW1 = 0;
   localparam int SLOT_SW0 = 1;
   localparam int SLOT_PERI = 2;
   localparam int SLOT_P0_TX = 3;
   localparam int SLOT_P0_RX = 4;
   localparam int SLOT_P1_TX = 5;
   localparam int SLOT_P1_RX = 6;
   localparam int SLOT_TIMER = 7;

   // Data bus access from the core
   typedef struct packed {
      logic rd;
      logic wr;
      logic [13:0] addr;
      logic [15:0] wdata;
   } mmia_dm_req_t;

   // Program bus access from the core
   typedef struct packed {
      logic rd;
      logic wr;
      logic [13:0] addr;
      logic [23:0] wdata;
   } mmia_pm_req_t;

   // Core interrupt source levels
   typedef struct packed {
      logic port0_rx;
      logic port0_tx;
      logic port1_rx;
      logic port1_tx;
      logic timer;
      logic soft0;
      logic soft1;
   } mmia_core_src_t;

   typedef enum logic [1:0] {
      MMIA_ST_RESET = 2'b00,
      MMIA_ST_RUN = 2'b01
   } mmia_state_t;

endpackage

/* File: hdl/mmia_ram.sv */
/*
 * Single port synchronous RAM with registered read data.
 * Assumes one clock; write and read never collide meaningfully (write wins, old data read).
 */
`timescale 1ns/1ps
module mmia_ram #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 1024,
   parameter int AW = 10
) (
   input wire logic sys_clk_in,
   input wire logic we_in,
   input wire logic re_in,
   input wire logic [AW-1:0] addr_in,
   input wire logic [WIDTH-1:0] wdata_in,
   output logic [WIDTH-1:0] rdata_out
);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] rdata_reg;

   // ------------------------------------------------------------------
   // Storage; no reset so it maps onto block RAM
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (we_in) begin
         mem[addr_in] <= wdata_in;
      end
      if (re_in) begin
         rdata_reg <= mem[addr_in];
      end
   end

   assign rdata_out = rdata_reg;

endmodule

/* File: hdl/mmia_top.sv */
/*
 * Memory map decode and interrupt aggregation for the motor-control processor.
 * Assumes the core presents one program and one data access per cycle and
 * samples read data two cycles later, three for peripherals; ROM image arrives on a port from a
 * mask-ROM macro; pin inputs come from outside and are synchronised here.
 */
`timescale 1ns/1ps
module mmia_top
   import mmia_pkg::*;
#(
   parameter int DIO_LINES = 24
) (
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire mmia_pm_req_t pm_req_in,
   output logic [23:0] pm_rdata_out,
   output logic [13:0] pm_rom_addr_out,
   input wire logic [23:0] pm_rom_data_in,
   input wire mmia_dm_req_t dm_req_in,
   output logic [15:0] dm_rdata_out,
   output logic peri_sel_out,
   output logic peri_wr_out,
   output logic [7:0] peri_addr_out,
   output logic [15:0] peri_wdata_out,
   input wire logic [15:0] peri_rdata_in,
   output logic [13:0] boot_fetch_addr_out,
   output logic [13:0] user_entry_addr_out,
   input wire logic port1_as_flags_in,
   input wire logic ext_request_a_b_in,
   input wire logic ext_request_b_b_in,
   input wire mmia_core_src_t core_src_in,
   input wire logic [DIO_LINES-1:0] digital_io_lines_in,
   input wire logic pwm_period_pulse_in,
   input wire logic pwm_shutdown_input_in,
   input wire logic [7:0] core_mask_in,
   input wire logic [25:0] peri_mask_in,
   output logic peripheral_irq_line_out,
   output logic [CORE_IRQ_N-1:0] core_pend_out,
   output logic irq_valid_out,
   output logic [2:0] irq_slot_out
);

   // ------------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------------
   function automatic logic in_range(input logic [13:0] a, input logic [13:0] lo,
                                     input logic [13:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [2:0] first_set(input logic [7:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      first_set = r;
   endfunction

   // ------------------------------------------------------------------
   // Reset state: boot address outputs
   // ------------------------------------------------------------------
   mmia_state_t state_reg;
   mmia_state_t state_next;

   // Leaves reset state on the first edge after release
   always_comb begin
      case (state_reg)
         MMIA_ST_RESET: state_next = MMIA_ST_RUN;
         MMIA_ST_RUN: state_next = MMIA_ST_RUN;
         default: state_next = MMIA_ST_RESET;
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_reg <= MMIA_ST_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   logic [13:0] boot_addr_reg;
   logic [13:0] user_addr_reg;

   // Constant entry points held in flops so outputs come from registers
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         boot_addr_reg <= PM_ROM_BASE;
         user_addr_reg <= PM_USER_ENTRY;
      end else begin
         boot_addr_reg <= PM_ROM_BASE;
         user_addr_reg <= PM_USER_ENTRY;
      end
   end

   assign boot_fetch_addr_out = boot_addr_reg;
   assign user_entry_addr_out = user_addr_reg;

   // ------------------------------------------------------------------
   // Program memory decode
   // ------------------------------------------------------------------
   logic pm_ram_hit;
   logic pm_rom_hit;
   logic pm_ram_we;
   logic pm_ram_re;
   logic [23:0] pm_ram_rdata;

   // Vector table at 0x0000-0x002F is ordinary RAM the monitor fills
   always_comb begin
      pm_ram_hit = pm_req_in.addr < PM_ROM_BASE;
      pm_rom_hit = in_range(pm_req_in.addr, PM_ROM_BASE, PM_ROM_END);
      pm_ram_we = pm_ram_hit && pm_req_in.wr;
      pm_ram_re = pm_ram_hit && pm_req_in.rd;
   end

   mmia_ram #(
      .WIDTH(24),
      .DEPTH(PM_DEPTH),
      .AW(11)
   ) u_pm_ram (
      .sys_clk_in(sys_clk_in),
      .we_in(pm_ram_we),
      .re_in(pm_ram_re),
      .addr_in(pm_req_in.addr[10:0]),
      .wdata_in(pm_req_in.wdata),
      .rdata_out(pm_ram_rdata)
   );

   logic pm_sel_ram_reg;
   logic pm_sel_rom_reg;
   logic pm_sel_ram_next;
   logic pm_sel_rom_next;
   logic [13:0] rom_addr_reg;
   logic [13:0] rom_addr_next;

   // ROM macro sees a registered address; ROM writes go nowhere
   always_comb begin
      pm_sel_ram_next = pm_ram_re;
      pm_sel_rom_next = pm_rom_hit && pm_req_in.rd;
      rom_addr_next = pm_rom_hit ? pm_req_in.addr : rom_addr_reg;
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pm_sel_ram_reg <= 1'b0;
         pm_sel_rom_reg <= 1'b0;
         rom_addr_reg <= PM_ROM_BASE;
      end else begin
         pm_sel_ram_reg <= pm_sel_ram_next;
         pm_sel_rom_reg <= pm_sel_rom_next;
         rom_addr_reg <= rom_addr_next;
      end
   end

   assign pm_rom_addr_out = rom_addr_reg;

   // Read mux registered a second time, adding a cycle after the RAM data flop
   logic [23:0] pm_rdata_reg;
   logic [23:0] pm_rdata_next;

   always_comb begin
      pm_rdata_next = 24'h000000;
      if (pm_sel_ram_reg) begin
         pm_rdata_next = pm_ram_rdata;
      end else if (pm_sel_rom_reg) begin
         pm_rdata_next = pm_rom_data_in;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pm_rdata_reg <= 24'h000000;
      end else begin
         pm_rdata_reg <= pm_rdata_next;
      end
   end

   assign pm_rdata_out = pm_rdata_reg;

   // ------------------------------------------------------------------
   // Data memory decode
   // ------------------------------------------------------------------
   logic dm_ram_hit;
   logic dm_peri_hit;
   logic [15:0] dm_ram_rdata;

   // Monitor traffic uses these same decodes, nothing privileged
   always_comb begin
      dm_ram_hit = in_range(dm_req_in.addr, DM_RAM_BASE, DM_RAM_END);
      dm_peri_hit = in_range(dm_req_in.addr, DM_PERI_BASE, DM_PERI_END);
   end

   mmia_ram #(
      .WIDTH(16),
      .DEPTH(DM_DEPTH),
      .AW(10)
   ) u_dm_ram (
      .sys_clk_in(sys_clk_in),
      .we_in(dm_ram_hit && dm_req_in.wr),
      .re_in(dm_ram_hit && dm_req_in.rd),
      .addr_in(dm_req_in.addr[9:0]),
      .wdata_in(dm_req_in.wdata),
      .rdata_out(dm_ram_rdata)
   );

   logic dm_sel_ram_reg;
   logic dm_sel_peri_reg;
   logic peri_sel_reg;
   logic peri_wr_reg;
   logic [7:0] peri_addr_reg;
   logic [15:0] peri_wdata_reg;
   logic dm_sel_ram_next;
   logic dm_sel_peri_next;
   logic peri_sel_next;
   logic peri_wr_next;

   // Peripheral strobe is one registered cycle; data read back the cycle after
   always_comb begin
      dm_sel_ram_next = dm_ram_hit && dm_req_in.rd;
      peri_sel_next = dm_peri_hit && (dm_req_in.rd || dm_req_in.wr);
      peri_wr_next = dm_peri_hit && dm_req_in.wr;
      dm_sel_peri_next = peri_sel_reg && !peri_wr_reg;
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         dm_sel_ram_reg <= 1'b0;
         dm_sel_peri_reg <= 1'b0;
         peri_sel_reg <= 1'b0;
         peri_wr_reg <= 1'b0;
         peri_addr_reg <= 8'h00;
         peri_wdata_reg <= 16'h0000;
      end else begin
         dm_sel_ram_reg <= dm_sel_ram_next;
         dm_sel_peri_reg <= dm_sel_peri_next;
         peri_sel_reg <= peri_sel_next;
         peri_wr_reg <= peri_wr_next;
         peri_addr_reg <= dm_req_in.addr[7:0];
         peri_wdata_reg <= dm_req_in.wdata;
      end
   end

   assign peri_sel_out = peri_sel_reg;
   assign peri_wr_out = peri_wr_reg;
   assign peri_addr_out = peri_addr_reg;
   assign peri_wdata_out = peri_wdata_reg;

   logic [15:0] dm_rdata_reg;
   logic [15:0] dm_rdata_next;

   // Unmapped reads give zero
   always_comb begin
      dm_rdata_next = 16'h0000;
      if (dm_sel_ram_reg) begin
         dm_rdata_next = dm_ram_rdata;
      end else if (dm_sel_peri_reg) begin
         dm_rdata_next = peri_rdata_in;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         dm_rdata_reg <= 16'h0000;
      end else begin
         dm_rdata_reg <= dm_rdata_next;
      end
   end

   assign dm_rdata_out = dm_rdata_reg;

   // ------------------------------------------------------------------
   // Pin synchronisers: three stages, change accepted when 2nd and 3rd agree
   // ------------------------------------------------------------------
   localparam int PIN_N = DIO_LINES + 4;
   logic [PIN_N-1:0] pin_raw;
   logic [PIN_N-1:0] sync1_reg;
   logic [PIN_N-1:0] sync2_reg;
   logic [PIN_N-1:0] sync3_reg;
   logic [PIN_N-1:0] pin_reg;
   logic [PIN_N-1:0] pin_next;

   always_comb begin
      pin_raw = {!ext_request_b_b_in, !ext_request_a_b_in, pwm_shutdown_input_in,
                 pwm_period_pulse_in, digital_io_lines_in};
      for (int i = 0; i < PIN_N; i++) begin
         pin_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : pin_reg[i];
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
         pin_reg <= '0;
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         pin_reg <= pin_next;
      end
   end

   // ------------------------------------------------------------------
   // Interrupt aggregation
   // ------------------------------------------------------------------
   logic [PERI_IRQ_N-1:0] peri_src;
   logic [CORE_IRQ_N-1:0] core_src;
   logic peri_any;
   logic [CORE_IRQ_N-1:0] core_live;

   // Digital I/O lines occupy bits 0-23, PWM pulse 24, shutdown 25
   always_comb begin
      peri_src = pin_reg[PERI_IRQ_N-1:0];
      peri_any = |(peri_src & peri_mask_in);
      core_src = '0;
      core_src[SLOT_SW1] = core_src_in.soft1;
      core_src[SLOT_SW0] = core_src_in.soft0;
      core_src[SLOT_PERI] = peripheral_irq_line_out;
      core_src[SLOT_P0_TX] = core_src_in.port0_tx;
      core_src[SLOT_P0_RX] = core_src_in.port0_rx;
      // Port one pins double as ext requests when configured as flags
      core_src[SLOT_P1_TX] = port1_as_flags_in ? pin_reg[PERI_IRQ_N+1] : core_src_in.port1_tx;
      core_src[SLOT_P1_RX] = port1_as_flags_in ? pin_reg[PERI_IRQ_N] : core_src_in.port1_rx;
      core_src[SLOT_TIMER] = core_src_in.timer;
      core_live = core_src & core_mask_in;
   end

   logic peri_line_reg;
   logic [CORE_IRQ_N-1:0] core_pend_reg;
   logic irq_valid_reg;
   logic [2:0] irq_slot_reg;

   // Masks cleared by reset come from the core's own reset; outputs idle low
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         peri_line_reg <= 1'b0;
         core_pend_reg <= CORE_MASK_RST;
         irq_valid_reg <= 1'b0;
         irq_slot_reg <= 3'h0;
      end else begin
         peri_line_reg <= peri_any && (state_reg == MMIA_ST_RUN);
         core_pend_reg <= core_live;
         irq_valid_reg <= |core_live;
         irq_slot_reg <= first_set(core_live);
      end
   end

   assign peripheral_irq_line_out = peri_line_reg;
   assign core_pend_out = core_pend_reg;
   assign irq_valid_out = irq_valid_reg;
   assign irq_slot_out = irq_slot_reg;

endmodule
